/* File: conv_ctrl_pkg.sv */
// package: register map, field positions, reset values and frame layout of the control bank
package conv_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 16;
    localparam int FRAME_BITS = 24;
    localparam int CMD_BITS = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] MAIN_CONFIGURATION_ADDR = 4'h0;
    localparam logic [3:0] RESERVED_ONE_ADDR = 4'h1;
    localparam logic [3:0] FIRST_CHANNEL_OFFSET_ADDR = 4'h2;
    localparam logic [3:0] FIRST_CHANNEL_RANGE_ADDR = 4'h3;
    localparam logic [3:0] CALIBRATION_ADJUST_ADDR = 4'h4;
    localparam logic [3:0] CALIBRATION_VALUES_ADDR = 4'h5;
    localparam logic [3:0] BIAS_ADJUST_ADDR = 4'h6;
    localparam logic [3:0] INTERLEAVE_TIMING_ADJUST_ADDR = 4'h7;
    localparam logic [3:0] RESERVED_EIGHT_ADDR = 4'h8;
    localparam logic [3:0] RESERVED_NINE_ADDR = 4'h9;
    localparam logic [3:0] SECOND_CHANNEL_OFFSET_ADDR = 4'hA;
    localparam logic [3:0] SECOND_CHANNEL_RANGE_ADDR = 4'hB;
    localparam logic [3:0] SAMPLE_DELAY_COARSE_ADDR = 4'hC;
    localparam logic [3:0] SAMPLE_DELAY_FINE_ADDR = 4'hD;
    localparam logic [3:0] MULTI_CHIP_SYNC_ADDR = 4'hE;
    localparam logic [3:0] RESERVED_FIFTEEN_ADDR = 4'hF;

    // one bit per location: set where a read/write register lives
    localparam logic [15:0] RW_MAP = 16'h7CFD;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_FIRST_PD_BIT = 11;
    localparam int CFG_SECOND_PD_BIT = 10;
    localparam logic [15:0] MAIN_CONFIGURATION_RESET = 16'h2000;
    localparam logic [15:0] OTHER_REG_RESET = 16'h0000;
    localparam logic [15:0] FULL_RATE_BIAS = 16'h1C00;
    localparam logic [1:0] FRAME_RSVD_PATTERN = 2'b10;
endpackage : conv_ctrl_pkg

/* File: pin_sync.sv */
// file holds a two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            pinSync <= RESET_VAL;
        end else begin
            meta_q <= pinIn;
            pinSync <= meta_q;
        end
    end
endmodule : pin_sync

/* File: conv_ctrl_regs.sv */
// file holds the serial-programmed control register bank of the converter
// ------------------------------------------------------------
// How it works
// - register settings act only in extended control mode; ignored in pin mode
// - sixteen locations by four-bit address, twelve read/write, rest reserved
// - fixed decode of offsets 0h..Fh; 1h, 8h, 9h, Fh reserved
// - power-on reset gives every bit a defined state; configuration is 2000h
// - configuration bit 11 set powers first channel down
// - first channel down if register bit or its pin asks
// - configuration bit 10 set powers second channel down, independently
// - mode-select pin high returns all registers to defaults
// - 24-bit frame: read bit, 10, address msb first, don't-care, 16 data
// - read of reserved address returns all zeros
// - registers keep contents while channels are powered down
// ------------------------------------------------------------
`timescale 1ns/10ps
module conv_ctrl_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialSelectN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic controlModeSelectPin,
    input wire logic firstChannelPowerdownPin,
    input wire logic secondChannelPowerdownPin,
    output logic serialDataOut,
    output logic serialDataOutEn,
    output logic extendedControlMode,
    output logic firstChannelPowerdown,
    output logic secondChannelPowerdown,
    output logic [conv_ctrl_pkg::DATA_W-1:0] activeConfig,
    output logic [conv_ctrl_pkg::DATA_W-1:0] activeBias
);
    import conv_ctrl_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation and serial clock edges
    // ------------------------------------------------------------
    logic [5:0] pinSync;
    logic selN;
    logic sclkS;
    logic sdiS;
    logic eceS;
    logic pdiS;
    logic pdqS;
    logic sclkPrev_q;
    logic sclkRise;
    logic sclkFall;

    // select and mode pins idle high so a frame cannot start during reset
    pin_sync #(.WIDTH(6), .RESET_VAL(6'b10_1100)) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({serialSelectN, serialClk, serialDataIn, controlModeSelectPin,
                firstChannelPowerdownPin, secondChannelPowerdownPin}),
        .pinSync(pinSync)
    );

    assign {selN, sclkS, sdiS, eceS, pdiS, pdqS} = pinSync;
    assign sclkRise = sclkS && !sclkPrev_q && !selN;
    assign sclkFall = !sclkS && sclkPrev_q && !selN;

    // last sample of the serial clock; it resets to the parked-low level so reset fakes no edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
        end
    end

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    logic [4:0] bitCnt_q;
    logic [14:0] shiftIn_q;
    logic isRead_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] shiftOut_q;
    logic cmdDone;
    logic writeDone;
    logic [ADDR_W-1:0] cmdAddr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] regs_q [NUM_REGS];

    // the eighth rising edge carries the don't-care bit; command sits in bits 6:0
    assign cmdAddr = shiftIn_q[3:0];
    assign cmdDone = sclkRise && (bitCnt_q == 5'(CMD_BITS - 1));
    assign writeDone = sclkRise && (bitCnt_q == 5'(FRAME_BITS - 1)) && !isRead_q;
    assign wrData = {shiftIn_q, sdiS};
    assign rdData = RW_MAP[cmdAddr] ? regs_q[cmdAddr] : '0;

    // a frame cut short never reaches the write edge, so nothing is stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitCnt_q <= '0;
            shiftIn_q <= '0;
        end else if (selN) begin
            bitCnt_q <= '0;
        end else if (sclkRise && bitCnt_q != 5'(FRAME_BITS)) begin
            bitCnt_q <= bitCnt_q + 5'd1;
            shiftIn_q <= {shiftIn_q[13:0], sdiS};
        end
    end

    // command decode at the eighth bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isRead_q <= 1'b0;
            addr_q <= '0;
        end else if (cmdDone) begin
            isRead_q <= shiftIn_q[6];
            addr_q <= cmdAddr;
        end
    end

    // output shifts on falling edges; after sixteen falls the last bit is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shiftOut_q <= '0;
            serialDataOut <= 1'b0;
            serialDataOutEn <= 1'b0;
        end else begin
            if (cmdDone) begin
                shiftOut_q <= rdData;
            end else if (sclkFall && isRead_q && bitCnt_q >= 5'(CMD_BITS)
                         && bitCnt_q < 5'(FRAME_BITS)) begin
                serialDataOut <= shiftOut_q[DATA_W-1];
                shiftOut_q <= {shiftOut_q[DATA_W-2:0], 1'b0};
            end
            serialDataOutEn <= !selN && isRead_q && bitCnt_q >= 5'(CMD_BITS);
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // mode pin high holds every register at its default; power-down never touches them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= (i == 0) ? MAIN_CONFIGURATION_RESET : OTHER_REG_RESET;
            end
        end else if (eceS) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= (i == 0) ? MAIN_CONFIGURATION_RESET : OTHER_REG_RESET;
            end
        end else if (writeDone && RW_MAP[addr_q]) begin
            regs_q[addr_q] <= wrData;
        end
    end

    // ------------------------------------------------------------
    // effective controls
    // ------------------------------------------------------------
    logic ecmNow;
    logic [DATA_W-1:0] cfgEff;

    assign ecmNow = !eceS;
    assign cfgEff = ecmNow ? regs_q[MAIN_CONFIGURATION_ADDR] : MAIN_CONFIGURATION_RESET;

    // pins stay live in both modes; register bits only count in extended mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extendedControlMode <= 1'b0;
            firstChannelPowerdown <= 1'b0;
            secondChannelPowerdown <= 1'b0;
            activeConfig <= MAIN_CONFIGURATION_RESET;
            activeBias <= OTHER_REG_RESET;
        end else begin
            extendedControlMode <= ecmNow;
            firstChannelPowerdown <= pdiS || cfgEff[CFG_FIRST_PD_BIT];
            secondChannelPowerdown <= pdqS || cfgEff[CFG_SECOND_PD_BIT];
            activeConfig <= cfgEff;
            activeBias <= ecmNow ? regs_q[BIAS_ADJUST_ADDR] : OTHER_REG_RESET;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_pin_mode_ignore: assert property (
        eceS |=> activeConfig == MAIN_CONFIGURATION_RESET && activeBias == OTHER_REG_RESET)
        else $error("register settings leaked out in pin mode");

    chk_reserved_unwritten: assert property (
        writeDone && !RW_MAP[addr_q] |=> $stable(regs_q[addr_q]))
        else $error("reserved location changed");

    chk_reserved_read_zero: assert property (
        cmdDone && !RW_MAP[cmdAddr] |=> shiftOut_q == 16'h0000)
        else $error("reserved read not zero");

    chk_write_lands: assert property (
        writeDone && RW_MAP[addr_q] && !eceS |=> regs_q[$past(addr_q)] == $past(wrData))
        else $error("write data not stored");

    chk_mode_defaults: assert property (
        eceS |=> regs_q[0] == MAIN_CONFIGURATION_RESET && regs_q[6] == OTHER_REG_RESET)
        else $error("registers not returned to defaults");

    chk_first_pd: assert property (
        pdiS || (ecmNow && regs_q[0][CFG_FIRST_PD_BIT]) |=> firstChannelPowerdown)
        else $error("first channel not powered down");

    chk_second_pd: assert property (
        !pdqS && !(ecmNow && regs_q[0][CFG_SECOND_PD_BIT]) |=> !secondChannelPowerdown)
        else $error("second channel powered down without cause");

    chk_first_pin_live: assert property (
        pdiS && ecmNow ##1 pdiS |=> firstChannelPowerdown)
        else $error("first channel pin ignored in extended mode");

    chk_sdo_quiet: assert property (
        selN |=> !serialDataOutEn)
        else $error("serial output driven while deselected");

    chk_keep_on_pd: assert property (
        firstChannelPowerdown && !writeDone && !eceS |=> $stable(regs_q[2]))
        else $error("register lost in power-down");
endmodule : conv_ctrl_regs

/* File: serial_master.sv */
// serial master model that drives access frames on the converter control link
`timescale 1ns/10ps
module serial_master (
    output logic selN,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoEn
);
    // idle: select high, clock parked low, data at its pull-up level
    initial begin
        selN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end
    // ------------------------------------------------------------
    // one frame; fewer than 24 bits aborts it early
    // ------------------------------------------------------------
    task automatic frame(input logic rdOp, input logic [3:0] addr, input logic [15:0] wdata,
                         input int nBits, output logic [15:0] rdata);
        logic [23:0] word;
        word = {rdOp, 2'b10, addr, 1'b0, wdata};
        rdata = 'x;
        #7 selN = 1'b0;
        #200;
        for (int i = 0; i < nBits; i++) begin
            // released during read data, so the pull-up wins
            sdi = (rdOp && i >= 8) ? 1'b1 : word[23-i];
            #100 sclk = 1'b1;
            #100;
            // sample late in the bit; an undriven line reads unknown
            if (i >= 8) rdata[23-i] = sdoEn ? sdo : 1'bx;
            sclk = 1'b0;
        end
        #100 selN = 1'b1;
        sdi = 1'b1;
        #300;
    endtask : frame
endmodule : serial_master

/* File: tb_conv_ctrl_regs.sv */
// self-checking testbench of the converter control register bank
`timescale 1ns/10ps
module tb_conv_ctrl_regs;
    import conv_ctrl_pkg::*;
    logic clk, rst, selN, sclk, sdi, modePin, pd1Pin, pd2Pin;
    logic sdo, sdoEn, extMode, pd1, pd2;
    logic [DATA_W-1:0] cfg, bias, rd;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    conv_ctrl_regs conv_ctrl_regs_i (.clk(clk), .rst(rst), .serialSelectN(selN),
        .serialClk(sclk), .serialDataIn(sdi), .controlModeSelectPin(modePin),
        .firstChannelPowerdownPin(pd1Pin), .secondChannelPowerdownPin(pd2Pin),
        .serialDataOut(sdo), .serialDataOutEn(sdoEn), .extendedControlMode(extMode),
        .firstChannelPowerdown(pd1), .secondChannelPowerdown(pd2),
        .activeConfig(cfg), .activeBias(bias));
    serial_master serial_master_i (.selN(selN), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdoEn(sdoEn));
    // ------------------------------------------------------------
    // clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // whole run is about 10k cycles, so 40k only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles > 40000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check16
    task automatic checkBit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkBit
    // bus tasks return at a falling edge so pins can follow at once
    task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
        serial_master_i.frame(1'b0, a, d, 24, rd);
        @(negedge clk);
    endtask : wrReg
    task automatic rdCheck(input logic [3:0] a, input logic [15:0] exp);
        serial_master_i.frame(1'b1, a, 16'h0000, 24, rd);
        check16(rd, exp);
        @(negedge clk);
    endtask : rdCheck
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        modePin = 1'b0;
        pd1Pin = 1'b0;
        pd2Pin = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        checkBit(extMode, 1'b1);
        check16(cfg, 16'h2000);
        rdCheck(4'h0, 16'h2000);
        rdCheck(4'h2, 16'h0000);
        // a distinct word per location exposes any decode slip
        for (int a = 0; a < 16; a++) wrReg(4'(a), 16'h0100 + 16'(a * 17));
        for (int a = 0; a < 16; a++) rdCheck(4'(a), (a == 1 || a == 8 || a == 9 || a == 15)
            ? 16'h0000 : 16'h0100 + 16'(a * 17));
        wrReg(4'h6, 16'h1C00);
        check16(bias, 16'h1C00);
        wrReg(4'h0, 16'h2800);
        checkBit(pd1, 1'b1);
        checkBit(pd2, 1'b0);
        rdCheck(4'h6, 16'h1C00);
        wrReg(4'h0, 16'h2400);
        checkBit(pd1, 1'b0);
        checkBit(pd2, 1'b1);
        pd1Pin = 1'b1;
        repeat (6) @(negedge clk);
        checkBit(pd1, 1'b1);
        // frame cut after twelve clocks must not write
        serial_master_i.frame(1'b0, 4'h0, 16'h2000, 12, rd);
        @(negedge clk);
        rdCheck(4'h0, 16'h2400);
        // pin mode: register settings give way to defaults and pins
        modePin = 1'b1;
        repeat (10) @(negedge clk);
        checkBit(extMode, 1'b0);
        check16(cfg, 16'h2000);
        checkBit(pd2, 1'b0);
        checkBit(pd1, 1'b1);
        wrReg(4'h6, 16'h1C00);
        check16(bias, 16'h0000);
        modePin = 1'b0;
        pd1Pin = 1'b0;
        pd2Pin = 1'b1;
        repeat (10) @(negedge clk);
        rdCheck(4'h6, 16'h0000);
        rdCheck(4'h0, 16'h2000);
        checkBit(pd2, 1'b1);
        checkBit(pd1, 1'b0);
        finish_test();
    end
endmodule : tb_conv_ctrl_regs
